/* File: hdl/asx_defs.vh */
// Purpose: constants for the subtract/swap/xor datapath slice
// Assumes: 32-bit AHB-Lite register word, byte addresses
// Notes:   offsets are byte addresses of aligned words
`ifndef ASX_DEFS_VH
`define ASX_DEFS_VH
`define ASX_OFF_ACC     8'h00
`define ASX_OFF_OPND    8'h04
`define ASX_OFF_CMD     8'h08
`define ASX_OFF_STATUS  8'h0c
`define ASX_OFF_RESULT  8'h10
`define ASX_OP_SUB_LIT  3'h0
`define ASX_OP_SUB_REG  3'h1
`define ASX_OP_SWAP     3'h2
`define ASX_OP_XOR_LIT  3'h3
`define ASX_OP_XOR_REG  3'h4
`define ASX_ST_CARRY    0
`define ASX_ST_NIB      1
`define ASX_ST_ZERO     2
`define ASX_ST_DEST     3
`define ASX_ACC_RST     8'h00
`define ASX_OPND_RST    8'h00
`define ASX_STAT_RST    3'h0
`endif

/* File: hdl/asx_alu.v */
// Purpose: combinational core of the five operations
// Assumes: operands already selected by the caller
// Notes:   flag enables say which flags the caller may update
`timescale 1ns/10ps
`include "asx_defs.vh"
module asx_alu
(
   op,
   acc,
   opnd,
   res,
   carry,
   nib_carry,
   zero,
   upd_carry,
   upd_zero,
   op_ok
);
   input  wire [2:0] op;
   input  wire [7:0] acc;
   input  wire [7:0] opnd;
   output reg  [7:0] res;
   output wire       carry;
   output wire       nib_carry;
   output wire       zero;
   output reg        upd_carry;
   output reg        upd_zero;
   output reg        op_ok;

   wire [8:0] diff;
   wire [4:0] ndiff;

   assign diff  = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
   assign ndiff = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
   assign carry     = diff[8];
   assign nib_carry = ndiff[4];
   assign zero      = (res == 8'h00);

   always @*
   begin
      res       = 8'h00;
      upd_carry = 1'b0;
      upd_zero  = 1'b0;
      op_ok     = 1'b1;
      case (op)
         `ASX_OP_SUB_LIT, `ASX_OP_SUB_REG:
         begin
            res       = diff[7:0];
            upd_carry = 1'b1;
            upd_zero  = 1'b1;
         end
         `ASX_OP_SWAP:
            res = {opnd[3:0], opnd[7:4]};
         `ASX_OP_XOR_LIT, `ASX_OP_XOR_REG:
         begin
            res      = acc ^ opnd;
            upd_zero = 1'b1;
         end
         default:
            op_ok = 1'b0;
      endcase
   end
endmodule

/* File: hdl/asx_top.v */
// What this block does
// - subtract-from-literal puts literal minus accumulator into the accumulator.
// - subtract-from-literal updates carry, nibble-carry and zero flags only.
// - subtract-from-register computes operand minus accumulator, to acc or operand.
// - nibble-exchange swaps operand nibbles, goes to the select target, flags kept.
// - xor-literal puts accumulator xor literal in the accumulator, zero flag only.
// - xor-register xors acc with operand, to acc or operand, zero flag only.
// Purpose: 8-bit subtract/swap/xor datapath slice with AHB-Lite access
// Assumes: single word transfers, one clock, async active-low reset
// Notes:   a write of op 0 to 4 to the command word executes one operation, ops 5 to 7 do nothing
`timescale 1ns/10ps
`include "asx_defs.vh"
module asx_top
(
   clock,
   nrst,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hrdata,
   hreadyout,
   hresp
);
   input  wire        clock;
   input  wire        nrst;
   input  wire        hsel;
   input  wire [31:0] haddr;
   input  wire [1:0]  htrans;
   input  wire        hwrite;
   input  wire [2:0]  hsize;
   input  wire [31:0] hwdata;
   input  wire        hready;
   output reg  [31:0] hrdata;
   output wire        hreadyout;
   output wire        hresp;

   reg  [7:0] acc_reg;
   reg  [7:0] opnd_reg;
   reg  [2:0] status_reg;
   reg        dest_reg;
   reg  [7:0] result_reg;
   reg  [2:0] lastop_reg;
   reg        wr_pend_reg;
   reg        rd_pend_reg;
   reg  [7:0] addr_reg;

   wire       take;
   reg  [2:0] op;
   reg  [7:0] alu_b;
   wire [7:0] res;
   wire       carry;
   wire       nib_carry;
   wire       zero;
   wire       upd_carry;
   wire       upd_zero;
   wire       op_ok;
   wire       do_cmd;
   wire       to_acc;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign take      = hsel & hready & htrans[1];
   assign do_cmd    = wr_pend_reg & (addr_reg == `ASX_OFF_CMD) & op_ok;

   // command word: [2:0] op, [3] target select, [15:8] literal
   always @*
   begin
      op    = hwdata[2:0];
      alu_b = opnd_reg;
      if ((op == `ASX_OP_SUB_LIT) || (op == `ASX_OP_XOR_LIT))
         alu_b = hwdata[15:8];
   end

   assign to_acc = (op == `ASX_OP_SUB_LIT) || (op == `ASX_OP_XOR_LIT) || !hwdata[3];

   asx_alu u_alu
   (
      .op        (op),
      .acc       (acc_reg),
      .opnd      (alu_b),
      .res       (res),
      .carry     (carry),
      .nib_carry (nib_carry),
      .zero      (zero),
      .upd_carry (upd_carry),
      .upd_zero  (upd_zero),
      .op_ok     (op_ok)
   );

   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end
      else
      begin
         wr_pend_reg <= take & hwrite;
         rd_pend_reg <= take & !hwrite;
         if (take)
            addr_reg <= haddr[7:0];
      end
   end

   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         acc_reg    <= `ASX_ACC_RST;
         opnd_reg   <= `ASX_OPND_RST;
         status_reg <= `ASX_STAT_RST;
         dest_reg   <= 1'b0;
         result_reg <= 8'h00;
         lastop_reg <= 3'h0;
      end
      else if (do_cmd)
      begin
         result_reg <= res;
         lastop_reg <= op;
         dest_reg   <= !to_acc;
         if (to_acc)
            acc_reg <= res;
         else
            opnd_reg <= res;
         if (upd_carry)
         begin
            status_reg[`ASX_ST_CARRY] <= carry;
            status_reg[`ASX_ST_NIB]   <= nib_carry;
         end
         if (upd_zero)
            status_reg[`ASX_ST_ZERO] <= zero;
      end
      else if (wr_pend_reg)
      begin
         if (addr_reg == `ASX_OFF_ACC)
            acc_reg <= hwdata[7:0];
         if (addr_reg == `ASX_OFF_OPND)
            opnd_reg <= hwdata[7:0];
         if (addr_reg == `ASX_OFF_STATUS)
            status_reg <= hwdata[2:0];
      end
   end

   // read data registered in the address phase for unmapped reads too
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         hrdata <= 32'h00000000;
      else if (take & !hwrite)
      begin
         case (haddr[7:0])
            `ASX_OFF_ACC:    hrdata <= {24'h000000, acc_reg};
            `ASX_OFF_OPND:   hrdata <= {24'h000000, opnd_reg};
            `ASX_OFF_CMD:    hrdata <= {29'h00000000, lastop_reg};
            `ASX_OFF_STATUS: hrdata <= {28'h0000000, dest_reg, status_reg};
            `ASX_OFF_RESULT: hrdata <= {24'h000000, result_reg};
            default:         hrdata <= 32'h00000000;
         endcase
      end
   end
endmodule

/* File: testbench/asx_monitor.sv */
// Purpose: port checks for asx_top
// Assumes: zero-wait slave
// Notes:   read data latched at address phase
`timescale 1ns/10ps
module asx_monitor
(
   input logic        clock,
   input logic        nrst,
   input logic        hsel,
   input logic [31:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic [2:0]  hsize,
   input logic [31:0] hwdata,
   input logic        hready,
   input logic [31:0] hrdata,
   input logic        hreadyout,
   input logic        hresp
);
   logic       rd_reg;
   logic [7:0] adr_reg;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         rd_reg  <= 1'b0;
         adr_reg <= 8'h00;
      end
      else
      begin
         rd_reg  <= hsel & hready & htrans[1] & ~hwrite;
         adr_reg <= haddr[7:0];
      end
   ready_high_a: assert property (hreadyout) else $error("ready low");
   resp_okay_a: assert property (!hresp) else $error("resp error");
   rdata_hold_a: assert property (!rd_reg |-> $stable(hrdata)) else $error("rdata moved");
   acc_width_a: assert property (rd_reg && adr_reg == 8'h00 |-> hrdata[31:8] == 24'h0)
      else $error("acc high bits");
   opnd_width_a: assert property (rd_reg && adr_reg == 8'h04 |-> hrdata[31:8] == 24'h0)
      else $error("operand high bits");
   stat_width_a: assert property (rd_reg && adr_reg == 8'h0c |-> hrdata[31:4] == 28'h0)
      else $error("status high bits");
   unmap_zero_a: assert property (rd_reg && adr_reg == 8'h14 |-> hrdata == 32'h0)
      else $error("unmapped read");
endmodule
bind asx_top asx_monitor mon (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
   .hwdata, .hready, .hrdata, .hreadyout, .hresp);

/* File: testbench/asx_host.sv */
// Purpose: bus master in place of the decoder
// Assumes: single word transfers
// Notes:   tmo counts waits that ran out
`timescale 1ns/10ps
module asx_host
(
   input  logic        clock,
   input  logic        hready,
   input  logic [31:0] hrdata,
   output logic [1:0]  htrans,
   output logic [31:0] haddr,
   output logic        hwrite,
   output logic [31:0] hwdata,
   output int          tmo
);
   initial
   begin
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      tmo = 0;
   end
   task hold;
      int n;
      n = 0;
      @(posedge clock);
      while (hready !== 1'b1 && n < 50)
      begin
         @(posedge clock);
         n++;
      end
      tmo += n / 50;
   endtask
   task xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hold;
      htrans <= 2'h0;
      hwdata <= d;
      hold;
      r = hrdata;
   endtask
endmodule

/* File: testbench/testbench.sv */
// Purpose: self-checking bench for asx_top
// Assumes: host model drives the bus
// Notes:   run() works out the expectations of every operation test
`timescale 1ns/10ps
module testbench;
   logic        clock;
   logic        nrst;
   logic [1:0]  htrans;
   logic [31:0] haddr;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   int          tmo;
   int          errors;
   int          cmp_count;
   logic [7:0]  res_q;
   logic        tg_q;
   logic [2:0]  op_q;
   asx_top dut (.clock, .nrst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
   asx_host host (.clock, .hready(hreadyout), .hrdata, .htrans, .haddr, .hwrite, .hwdata, .tmo);
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task complete_run;
      $display("errors %0d compares %0d", errors + tmo, cmp_count);
      if (errors + tmo == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      host.xfer(1'b0, {24'h0, a}, 32'h0, r);
      if (tmo != 0)
         complete_run;
      cmp_count++;
      if (r !== e)
      begin
         errors++;
         $display("MISMATCH reg_%h exp %h got %h", a, e, r);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      host.xfer(1'b1, {24'h0, a}, d, r);
      if (tmo != 0)
         complete_run;
   endtask
   task run(input logic [2:0] op, input logic t, input logic [7:0] k, a, f,
      input logic [2:0] s);
      logic [7:0] x;
      logic [7:0] r;
      logic       lit;
      lit = op == 3'h0 || op == 3'h3;
      x = lit ? k : f;
      case (op)
         3'h0, 3'h1: r = x - a;
         3'h2: r = {f[3:0], f[7:4]};
         default: r = x ^ a;
      endcase
      wr(8'h00, {24'h0, a});
      wr(8'h04, {24'h0, f});
      wr(8'h0c, {29'h0, s});
      wr(8'h08, {16'h0, k, 4'h0, t, op});
      if (op < 3'h2)
         s[1:0] = {x[3:0] >= a[3:0], x >= a};
      if (op != 3'h2 && op < 3'h5)
         s[2] = r == 8'h0;
      if (op < 3'h5)
         res_q = r;
      // literal forms always land in the accumulator
      if (op < 3'h5)
         tg_q = t && !lit;
      if (op < 3'h5)
         op_q = op;
      chk(8'h00, {24'h0, op > 3'h4 || !lit && t ? a : r});
      chk(8'h04, {24'h0, op < 3'h5 && !lit && t ? r : f});
      chk(8'h0c, {28'h0, tg_q, s});
      chk(8'h10, {24'h0, res_q});
      chk(8'h08, {29'h0, op_q});
   endtask
   initial
   begin
      nrst = 1'b0;
      errors = 0;
      cmp_count = 0;
      res_q = 8'h00;
      tg_q = 1'b0;
      op_q = 3'h0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      chk(8'h00, 32'h0);
      chk(8'h0c, 32'h0);
      run(3'h0, 1'b0, 8'h35, 8'h35, 8'h77, 3'h0);
      run(3'h0, 1'b0, 8'h00, 8'h01, 8'h77, 3'h7);
      run(3'h0, 1'b1, 8'h80, 8'h18, 8'h66, 3'h0);
      run(3'h1, 1'b1, 8'h99, 8'h01, 8'h20, 3'h0);
      run(3'h1, 1'b0, 8'h99, 8'h20, 8'h10, 3'h4);
      run(3'h2, 1'b0, 8'h99, 8'h11, 8'ha5, 3'h5);
      run(3'h2, 1'b1, 8'h99, 8'h11, 8'h3c, 3'h2);
      run(3'h3, 1'b0, 8'h5a, 8'h5a, 8'h77, 3'h3);
      run(3'h4, 1'b1, 8'h99, 8'hff, 8'h0f, 3'h4);
      run(3'h4, 1'b0, 8'h99, 8'h81, 8'h81, 3'h3);
      run(3'h5, 1'b1, 8'h99, 8'h12, 8'h34, 3'h1);
      chk(8'h14, 32'h0);
      complete_run;
   end
endmodule
